//--- design/line_unit_global_config.sv
// Global line unit configuration registers with an AXI4-Lite slave and interrupt logic.
//
// Functional notes
// RULE1: Software writes zero to control two bit seven; other bits unused.
// RULE2: Control three is eight bits of plain storage, reset zero.
// RULE3: Four-bit code declares master clock rate; codes two to seven reserved.
// RULE4: Board must supply a master clock matching the programmed code.
// RULE5: Channel zero summary flag clears itself when its register is read.
// RULE6: Flag reads one if channel zero interrupted since the previous read.
// RULE7: Summary register bits seven to one read back zero.
// RULE8: Transmit supply enable bit n controls channel n, reset zero.
// RULE9: Each transmit supply enable affects only its own channel.
// RULE10: Receive supply enable bit n controls channel n, reset zero.
// RULE11: Each receive supply enable affects only its own channel.
// RULE12: Global transmit supply enable is bit seven of control one.
// RULE13: Global receive supply enable is bit six of control one.
// RULE14: A channel zero event coinciding with a read keeps the flag set.
// RULE15: Channel supply active only when global and channel enables both set.
module line_unit_global_config
  import line_unit_pkg::*;
(
  input  wire logic        aclk,            // System clock, 10 MHz
  input  wire logic        aresetn,         // Synchronous reset, active low
  input  wire logic [31:0] s_axi_awaddr,    // Write address
  input  wire logic [2:0]  s_axi_awprot,    // Write protection, ignored
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [31:0] s_axi_araddr,    // Read address
  input  wire logic [2:0]  s_axi_arprot,    // Read protection, ignored
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  input  wire logic        ch0_irq_event,   // Channel zero interrupt pulse, same clock
  output line_unit_pkg::supply_active_s supply_active,  // Per-channel supply active
  output line_unit_pkg::clock_rate_s    clock_rate,     // Declared master clock rate
  output logic             irq              // Level interrupt, active high
);

  // Write channel state.
  wr_state_e   wr_state_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;

  // Read channel state.
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // Register file.
  logic [7:0]  control_one_reg;
  logic [7:0]  control_two_reg;
  logic [7:0]  control_three_reg;
  logic [7:0]  master_clock_reg;
  logic        ch0_flag_reg;
  logic [7:0]  tx_enables_reg;
  logic [7:0]  rx_enables_reg;
  logic [EVENT_COUNT-1:0] irq_status_reg;
  logic [EVENT_COUNT-1:0] irq_mask_reg;
  logic        irq_reg;

  supply_active_s supply_reg;
  clock_rate_s    rate_reg;

  // Handshakes.
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take  = s_axi_wvalid & wready_reg;
  wire b_done  = bvalid_reg & s_axi_bready;
  wire ar_take = s_axi_arvalid & arready_reg;
  wire r_done  = rvalid_reg & s_axi_rready;

  // A write executes once both halves are held, one cycle after the later one is taken.
  wire wr_fire = (wr_state_reg == WR_COLLECT) & aw_held_reg & w_held_reg;
  wire lane0   = w_strb_reg[0];

  wire aw_held_next = b_done ? 1'b0 : (aw_held_reg | aw_take);
  wire w_held_next  = b_done ? 1'b0 : (w_held_reg | w_take);

  // Write address decode.
  wire wsel_one   = aw_addr_reg == ADDR_GLOBAL_CONTROL_ONE;
  wire wsel_two   = aw_addr_reg == ADDR_GLOBAL_CONTROL_TWO;
  wire wsel_three = aw_addr_reg == ADDR_GLOBAL_CONTROL_THREE;
  wire wsel_clock = aw_addr_reg == ADDR_MASTER_CLOCK_SELECT;
  wire wsel_summ  = aw_addr_reg == ADDR_CHANNEL_IRQ_SUMMARY;
  wire wsel_tx    = aw_addr_reg == ADDR_TX_SUPPLY_ENABLES;
  wire wsel_rx    = aw_addr_reg == ADDR_RX_SUPPLY_ENABLES;
  wire wsel_stat  = aw_addr_reg == ADDR_IRQ_STATUS;
  wire wsel_mask  = aw_addr_reg == ADDR_IRQ_MASK;
  wire wsel_hit   = wsel_one | wsel_two | wsel_three | wsel_clock | wsel_summ |
                    wsel_tx | wsel_rx | wsel_stat | wsel_mask;

  wire wr_one   = wr_fire & lane0 & wsel_one;
  wire wr_two   = wr_fire & lane0 & wsel_two;
  wire wr_three = wr_fire & lane0 & wsel_three;
  wire wr_clock = wr_fire & lane0 & wsel_clock;
  wire wr_tx    = wr_fire & lane0 & wsel_tx;
  wire wr_rx    = wr_fire & lane0 & wsel_rx;
  wire wr_stat  = wr_fire & lane0 & wsel_stat;
  wire wr_mask  = wr_fire & lane0 & wsel_mask;

  // Read address decode straight from the bus, since the read is answered at the taking edge.
  wire rsel_one   = s_axi_araddr == ADDR_GLOBAL_CONTROL_ONE;
  wire rsel_two   = s_axi_araddr == ADDR_GLOBAL_CONTROL_TWO;
  wire rsel_three = s_axi_araddr == ADDR_GLOBAL_CONTROL_THREE;
  wire rsel_clock = s_axi_araddr == ADDR_MASTER_CLOCK_SELECT;
  wire rsel_summ  = s_axi_araddr == ADDR_CHANNEL_IRQ_SUMMARY;
  wire rsel_tx    = s_axi_araddr == ADDR_TX_SUPPLY_ENABLES;
  wire rsel_rx    = s_axi_araddr == ADDR_RX_SUPPLY_ENABLES;
  wire rsel_stat  = s_axi_araddr == ADDR_IRQ_STATUS;
  wire rsel_mask  = s_axi_araddr == ADDR_IRQ_MASK;
  wire rsel_hit   = rsel_one | rsel_two | rsel_three | rsel_clock | rsel_summ |
                    rsel_tx | rsel_rx | rsel_stat | rsel_mask;

  wire [7:0] summary_word = {7'h00, ch0_flag_reg};  // RULE7

  wire [7:0] rd_byte =
    rsel_one   ? control_one_reg :
    rsel_two   ? control_two_reg :
    rsel_three ? control_three_reg :
    rsel_clock ? master_clock_reg :
    rsel_summ  ? summary_word :
    rsel_tx    ? tx_enables_reg :
    rsel_rx    ? rx_enables_reg :
    rsel_stat  ? {6'h00, irq_status_reg} :
    rsel_mask  ? {6'h00, irq_mask_reg} : 8'h00;

  // The read that takes the summary register is the read that clears it.
  wire summ_read = ar_take & rsel_summ;  // RULE5

  // A new event wins over the clear of the same cycle, so none is lost.
  wire ch0_flag_next = ch0_irq_event | (ch0_flag_reg & ~summ_read);  // RULE6 RULE14

  // Writing a reserved rate code is reported, since the device would not run on it.
  wire [3:0] new_code = w_data_reg[3:0];
  wire       code_bad = (new_code > CODE_1544_A) & (new_code < CODE_4096);
  wire       bad_code_event = wr_clock & code_bad;

  wire [EVENT_COUNT-1:0] events;
  assign events[EV_CH0_IRQ]  = ch0_irq_event;
  assign events[EV_BAD_CODE] = bad_code_event;

  wire [EVENT_COUNT-1:0] status_clear = wr_stat ? w_data_reg[EVENT_COUNT-1:0] : '0;
  wire [EVENT_COUNT-1:0] irq_status_next = events | (irq_status_reg & ~status_clear);

  // A channel runs its supply only with the global and its own enable both set.
  wire [7:0] tx_active_next =
    {8{control_one_reg[TX_GLOBAL_BIT]}} & tx_enables_reg;  // RULE12 RULE15 RULE9
  wire [7:0] rx_active_next =
    {8{control_one_reg[RX_GLOBAL_BIT]}} & rx_enables_reg;  // RULE13 RULE15 RULE11

  logic [14:0] decoded_khz;
  logic        decoded_valid;

  rate_code_decoder u_rate_decoder (
    .code  (master_clock_reg[3:0]),
    .khz   (decoded_khz),
    .valid (decoded_valid)
  );

  // Write channel: address and data are taken in either order, one write at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WR_COLLECT;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 32'h0;
      w_data_reg   <= 32'h0;
      w_strb_reg   <= 4'h0;
      awready_reg  <= 1'b1;
      wready_reg   <= 1'b1;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awready_reg <= ~aw_held_next;
      wready_reg  <= ~w_held_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      case (wr_state_reg)
        WR_COLLECT: begin
          if (wr_fire) begin
            wr_state_reg <= WR_RESPOND;
            bvalid_reg   <= 1'b1;
            bresp_reg    <= wsel_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESPOND: begin
          if (b_done) begin
            wr_state_reg <= WR_COLLECT;
            bvalid_reg   <= 1'b0;
          end
        end
        default: begin
          wr_state_reg <= WR_COLLECT;
          bvalid_reg   <= 1'b0;
        end
      endcase
    end
  end

  // Read channel: the data is captured at the edge that takes the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= {24'h0, rd_byte};
      rresp_reg   <= rsel_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // Only byte lane zero carries register data; other lanes are ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_one_reg   <= RST_GLOBAL_CONTROL;
      control_two_reg   <= RST_GLOBAL_CONTROL;
      control_three_reg <= RST_GLOBAL_CONTROL;
      master_clock_reg  <= RST_MASTER_CLOCK;
      tx_enables_reg    <= RST_SUPPLY_ENABLES;
      rx_enables_reg    <= RST_SUPPLY_ENABLES;
      irq_mask_reg      <= RST_IRQ;
    end else begin
      if (wr_one) begin
        control_one_reg <= w_data_reg[7:0];
      end
      if (wr_two) begin
        control_two_reg <= w_data_reg[7:0];  // RULE1
      end
      if (wr_three) begin
        control_three_reg <= w_data_reg[7:0];  // RULE2
      end
      if (wr_clock) begin
        master_clock_reg <= w_data_reg[7:0];  // RULE3
      end
      if (wr_tx) begin
        tx_enables_reg <= w_data_reg[7:0];  // RULE8
      end
      if (wr_rx) begin
        rx_enables_reg <= w_data_reg[7:0];  // RULE10
      end
      if (wr_mask) begin
        irq_mask_reg <= w_data_reg[EVENT_COUNT-1:0];
      end
    end
  end

  // Flags that hardware sets.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch0_flag_reg   <= 1'b0;
      irq_status_reg <= RST_IRQ;
      irq_reg        <= 1'b0;
    end else begin
      ch0_flag_reg   <= ch0_flag_next;
      irq_status_reg <= irq_status_next;
      irq_reg        <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Derived outputs are registered so that no port is driven through logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_reg <= '0;
      rate_reg   <= '0;
    end else begin
      supply_reg.tx  <= tx_active_next;
      supply_reg.rx  <= rx_active_next;
      rate_reg.code  <= master_clock_reg[3:0];  // RULE3
      rate_reg.khz   <= decoded_khz;
      rate_reg.valid <= decoded_valid;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign supply_active = supply_reg;
  assign clock_rate    = rate_reg;
  assign irq           = irq_reg;

endmodule

//--- design/line_unit_pkg.sv
// Shared constants and carrier types for the line unit global configuration block.
package line_unit_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [11:0] IDX_GLOBAL_CONTROL_ONE   = 12'hfe1;
  localparam logic [11:0] IDX_GLOBAL_CONTROL_TWO   = 12'hfe2;
  localparam logic [11:0] IDX_GLOBAL_CONTROL_THREE = 12'hfe3;
  localparam logic [11:0] IDX_MASTER_CLOCK_SELECT  = 12'hfe9;
  localparam logic [11:0] IDX_CHANNEL_IRQ_SUMMARY  = 12'hfea;
  localparam logic [11:0] IDX_TX_SUPPLY_ENABLES    = 12'hff0;
  localparam logic [11:0] IDX_RX_SUPPLY_ENABLES    = 12'hff1;
  localparam logic [11:0] IDX_IRQ_STATUS           = 12'hff8;
  localparam logic [11:0] IDX_IRQ_MASK             = 12'hff9;

  localparam logic [31:0] ADDR_GLOBAL_CONTROL_ONE   = {18'h0, IDX_GLOBAL_CONTROL_ONE, 2'h0};
  localparam logic [31:0] ADDR_GLOBAL_CONTROL_TWO   = {18'h0, IDX_GLOBAL_CONTROL_TWO, 2'h0};
  localparam logic [31:0] ADDR_GLOBAL_CONTROL_THREE = {18'h0, IDX_GLOBAL_CONTROL_THREE, 2'h0};
  localparam logic [31:0] ADDR_MASTER_CLOCK_SELECT  = {18'h0, IDX_MASTER_CLOCK_SELECT, 2'h0};
  localparam logic [31:0] ADDR_CHANNEL_IRQ_SUMMARY  = {18'h0, IDX_CHANNEL_IRQ_SUMMARY, 2'h0};
  localparam logic [31:0] ADDR_TX_SUPPLY_ENABLES    = {18'h0, IDX_TX_SUPPLY_ENABLES, 2'h0};
  localparam logic [31:0] ADDR_RX_SUPPLY_ENABLES    = {18'h0, IDX_RX_SUPPLY_ENABLES, 2'h0};
  localparam logic [31:0] ADDR_IRQ_STATUS           = {18'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [31:0] ADDR_IRQ_MASK             = {18'h0, IDX_IRQ_MASK, 2'h0};

  // Field positions.
  localparam int TX_GLOBAL_BIT  = 7;
  localparam int RX_GLOBAL_BIT  = 6;
  localparam int CH0_FLAG_BIT   = 0;
  localparam int EV_CH0_IRQ     = 0;
  localparam int EV_BAD_CODE    = 1;
  localparam int EVENT_COUNT    = 2;

  // Reset values.
  localparam logic [7:0] RST_GLOBAL_CONTROL = 8'h00;
  localparam logic [7:0] RST_MASTER_CLOCK   = 8'h01;
  localparam logic [7:0] RST_SUPPLY_ENABLES = 8'h00;
  localparam logic [1:0] RST_IRQ            = 2'h0;

  // Master clock rate codes and the rates they declare, in kHz.
  localparam logic [3:0] CODE_2048_A  = 4'h0;
  localparam logic [3:0] CODE_1544_A  = 4'h1;
  localparam logic [3:0] CODE_4096    = 4'h8;
  localparam logic [3:0] CODE_3088    = 4'h9;
  localparam logic [3:0] CODE_8192    = 4'ha;
  localparam logic [3:0] CODE_6176    = 4'hb;
  localparam logic [3:0] CODE_16384   = 4'hc;
  localparam logic [3:0] CODE_12352   = 4'hd;
  localparam logic [3:0] CODE_2048_B  = 4'he;
  localparam logic [3:0] CODE_1544_B  = 4'hf;

  localparam logic [14:0] KHZ_2048  = 15'h0800;
  localparam logic [14:0] KHZ_1544  = 15'h0608;
  localparam logic [14:0] KHZ_4096  = 15'h1000;
  localparam logic [14:0] KHZ_3088  = 15'h0c10;
  localparam logic [14:0] KHZ_8192  = 15'h2000;
  localparam logic [14:0] KHZ_6176  = 15'h1820;
  localparam logic [14:0] KHZ_16384 = 15'h4000;
  localparam logic [14:0] KHZ_12352 = 15'h3040;
  localparam logic [14:0] KHZ_NONE  = 15'h0000;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
  } supply_active_s;

  typedef struct packed {
    logic [3:0]  code;
    logic [14:0] khz;
    logic        valid;
  } clock_rate_s;

  typedef enum logic {WR_COLLECT, WR_RESPOND} wr_state_e;

endpackage

//--- design/rate_code_decoder.sv
// Decoder from the master clock rate code to the declared rate in kHz.
module rate_code_decoder
  import line_unit_pkg::*;
(
  input  wire logic [3:0]  code,  // Programmed master clock rate code
  output logic      [14:0] khz,   // Declared master clock rate in kHz
  output logic             valid  // Code is not a reserved one
);

  always_comb begin
    valid = 1'b1;
    case (code)
      CODE_2048_A, CODE_2048_B: khz = KHZ_2048;
      CODE_1544_A, CODE_1544_B: khz = KHZ_1544;
      CODE_4096:                khz = KHZ_4096;
      CODE_3088:                khz = KHZ_3088;
      CODE_8192:                khz = KHZ_8192;
      CODE_6176:                khz = KHZ_6176;
      CODE_16384:               khz = KHZ_16384;
      CODE_12352:               khz = KHZ_12352;
      default: begin
        khz   = KHZ_NONE;
        valid = 1'b0;
      end
    endcase
  end

endmodule

//--- test/line_unit_checker_properties.sv
// Port-level checker for the line unit global configuration block.
module line_unit_checker (
  input wire logic        aclk,           // clock
  input wire logic        aresetn,        // reset, active low
  input wire logic [31:0] s_axi_awaddr,   // write address
  input wire logic [2:0]  s_axi_awprot,   // unused
  input wire logic        s_axi_awvalid,  // aw valid
  input wire logic        s_axi_awready,  // aw ready
  input wire logic [31:0] s_axi_wdata,    // write data
  input wire logic [3:0]  s_axi_wstrb,    // strobes
  input wire logic        s_axi_wvalid,   // w valid
  input wire logic        s_axi_wready,   // w ready
  input wire logic [1:0]  s_axi_bresp,    // write response
  input wire logic        s_axi_bvalid,   // b valid
  input wire logic        s_axi_bready,   // b ready
  input wire logic [31:0] s_axi_araddr,   // read address
  input wire logic [2:0]  s_axi_arprot,   // unused
  input wire logic        s_axi_arvalid,  // ar valid
  input wire logic        s_axi_arready,  // ar ready
  input wire logic [31:0] s_axi_rdata,    // read data
  input wire logic [1:0]  s_axi_rresp,    // read response
  input wire logic        s_axi_rvalid,   // r valid
  input wire logic        s_axi_rready,   // r ready
  input wire logic        ch0_irq_event,  // channel zero event
  input wire line_unit_pkg::supply_active_s supply_active,  // supply active
  input wire line_unit_pkg::clock_rate_s    clock_rate,     // clock rate
  input wire logic        irq             // interrupt
);
  import line_unit_pkg::*;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic flag_model_reg;
  wire  aw_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire  ar_take = s_axi_arvalid && s_axi_arready;
  wire  sum_rd  = ar_take && s_axi_araddr == ADDR_CHANNEL_IRQ_SUMMARY;
  wire  aw_map  = s_axi_awaddr inside {ADDR_GLOBAL_CONTROL_ONE, ADDR_GLOBAL_CONTROL_TWO,
    ADDR_GLOBAL_CONTROL_THREE, ADDR_MASTER_CLOCK_SELECT, ADDR_CHANNEL_IRQ_SUMMARY,
    ADDR_TX_SUPPLY_ENABLES, ADDR_RX_SUPPLY_ENABLES, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
  wire  ar_map  = s_axi_araddr inside {ADDR_GLOBAL_CONTROL_ONE, ADDR_GLOBAL_CONTROL_TWO,
    ADDR_GLOBAL_CONTROL_THREE, ADDR_MASTER_CLOCK_SELECT, ADDR_CHANNEL_IRQ_SUMMARY,
    ADDR_TX_SUPPLY_ENABLES, ADDR_RX_SUPPLY_ENABLES, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};

  // Set beats clear, so an event landing on a read is never lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) flag_model_reg <= 1'b0;
    else if (ch0_irq_event) flag_model_reg <= 1'b1;
    else if (sum_rd) flag_model_reg <= 1'b0;
  end

  function automatic logic [14:0] rate_of(input logic [3:0] c);
    case (c)
      4'h0, 4'he: rate_of = KHZ_2048;
      4'h1, 4'hf: rate_of = KHZ_1544;
      4'h8: rate_of = KHZ_4096;
      4'h9: rate_of = KHZ_3088;
      4'ha: rate_of = KHZ_8192;
      4'hb: rate_of = KHZ_6176;
      4'hc: rate_of = KHZ_16384;
      4'hd: rate_of = KHZ_12352;
      default: rate_of = KHZ_NONE;
    endcase
  endfunction

  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped before taken");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped before taken");
  a_write_latency: assert property (aw_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after take");
  a_write_unmapped: assert property (aw_take && !aw_map |=> ##1 s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_read_unmapped: assert property (ar_take && !ar_map |=> s_axi_rvalid
    && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
  a_summary_reserved: assert property (sum_rd |=> s_axi_rdata[31:1] == 31'h0)
    else $error("summary reserved bits not zero");
  a_summary_flag: assert property (sum_rd |=>
    s_axi_rdata[0] == $past(flag_model_reg)) else $error("channel zero flag wrong");
  a_clock_decode: assert property ($past(aresetn) && $past(aresetn, 2) |->
    clock_rate.khz == rate_of(clock_rate.code)
    && clock_rate.valid == !(clock_rate.code inside {[4'h2:4'h7]}))
    else $error("rate decode wrong");
endmodule

bind line_unit_global_config line_unit_checker u_chk (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .ch0_irq_event, .supply_active, .clock_rate, .irq);

//--- test/tb_top.sv
// Self-checking bench for the line unit global configuration block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import line_unit_pkg::*;

  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        ch0_irq_event, irq;
  supply_active_s supply_active;
  clock_rate_s    clock_rate;
  int fails, samples_checked, i;
  logic [1:0] resp;
  logic [31:0] regs[7] = '{ADDR_GLOBAL_CONTROL_ONE, ADDR_GLOBAL_CONTROL_TWO,
    ADDR_GLOBAL_CONTROL_THREE, ADDR_MASTER_CLOCK_SELECT, ADDR_CHANNEL_IRQ_SUMMARY,
    ADDR_TX_SUPPLY_ENABLES, ADDR_RX_SUPPLY_ENABLES};
  logic [7:0] rst_vals[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};

  line_unit_global_config uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ch0_irq_event, .supply_active, .clock_rate, .irq);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Ready is raised only once the answer is seen, so every answer stalls one cycle.
  task automatic axi_write(input logic [31:0] addr, input logic [31:0] data);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    check({31'h0, s_axi_awvalid | s_axi_wvalid}, 32'h0, "write request not released");
    if (n == 100) check(1, 0, "write wait ran out");
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdc(input logic [31:0] addr, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    if (n == 100) check(1, 0, "read wait ran out");
    check(s_axi_rdata, exp, "read data");
    check({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] addr, input logic [7:0] data);
    axi_write(addr, {24'h0, data});
    check({30'h0, resp}, {30'h0, RESP_OKAY}, "write response");
  endtask

  function automatic logic [19:0] exp_rate(input logic [3:0] c);
    logic [14:0] k;
    case (c)
      4'h0, 4'he: k = KHZ_2048;
      4'h1, 4'hf: k = KHZ_1544;
      4'h8: k = KHZ_4096;
      4'h9: k = KHZ_3088;
      4'ha: k = KHZ_8192;
      4'hb: k = KHZ_6176;
      4'hc: k = KHZ_16384;
      4'hd: k = KHZ_12352;
      default: k = KHZ_NONE;
    endcase
    exp_rate = {c, k, !(c inside {[4'h2:4'h7]})};
  endfunction

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial begin
    #3000000;
    check(1, 0, "watchdog expired");
    results();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    s_axi_wstrb = 4'hf;
    ch0_irq_event = 1'b0;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check({12'h0, clock_rate}, {12'h0, exp_rate(4'h1)}, "rate after reset");
    for (i = 0; i < 7; i++) rdc(regs[i], {24'h0, rst_vals[i]}, RESP_OKAY);
    // Control two keeps bit seven clear, as software must.
    for (i = 0; i < 7; i++) wr(regs[i], (i == 4) ? 8'hff : 8'h3c + 8'(i));
    for (i = 0; i < 7; i++) rdc(regs[i], (i == 4) ? 32'h0 : 32'h3c + i, RESP_OKAY);
    check({16'h0, supply_active}, 32'h0, "supply without global");
    wr(ADDR_GLOBAL_CONTROL_ONE, 8'h80);
    for (i = 0; i < 8; i++) begin
      wr(ADDR_TX_SUPPLY_ENABLES, 8'h01 << i);
      repeat (2) @(posedge aclk);
      check({16'h0, supply_active}, {16'h0, 8'h01 << i, 8'h00}, "tx");
    end
    wr(ADDR_GLOBAL_CONTROL_ONE, 8'h40);
    for (i = 0; i < 8; i++) begin
      wr(ADDR_RX_SUPPLY_ENABLES, 8'h01 << i);
      repeat (2) @(posedge aclk);
      check({16'h0, supply_active}, {24'h0, 8'h01 << i}, "rx");
    end
    for (i = 0; i < 16; i++) begin
      wr(ADDR_MASTER_CLOCK_SELECT, 8'(i));
      repeat (2) @(posedge aclk);
      check({12'h0, clock_rate}, {12'h0, exp_rate(4'(i))}, "clock rate");
    end
    rdc(ADDR_IRQ_STATUS, 32'h2, RESP_OKAY);
    wr(ADDR_IRQ_STATUS, 8'h02);
    rdc(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
    @(posedge aclk);
    ch0_irq_event <= 1'b1;
    @(posedge aclk);
    ch0_irq_event <= 1'b0;
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0, "masked interrupt");
    wr(ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h1, "unmasked interrupt");
    wr(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0, "cleared interrupt");
    rdc(ADDR_CHANNEL_IRQ_SUMMARY, 32'h1, RESP_OKAY);
    rdc(ADDR_CHANNEL_IRQ_SUMMARY, 32'h0, RESP_OKAY);
    ch0_irq_event <= 1'b1;
    rdc(ADDR_CHANNEL_IRQ_SUMMARY, 32'h1, RESP_OKAY);
    ch0_irq_event <= 1'b0;
    rdc(ADDR_CHANNEL_IRQ_SUMMARY, 32'h1, RESP_OKAY);
    rdc(ADDR_CHANNEL_IRQ_SUMMARY, 32'h0, RESP_OKAY);
    axi_write(32'h3f90, 32'hff);
    check({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    rdc(32'h3f90, 32'h0, RESP_SLVERR);
    results();
  end
endmodule
